//--- afe_setup_control_regs.sv
// Setup register bank: clamp DAC, reset sample shift, channel select, power-down
//
// Summary of operation
// - Four-bit clamp DAC code, reset all ones, sets the clamp reference voltage.
// - Two-bit shift moves the reset sample in CDS mode only: advance one, default, delay one or two.
// - Channel select bit has no effect while single channel mode is off.
// - In single channel mode, select 0 picks odd channel, 1 picks even.
// - Any write to the soft reset location restores every register bit to default.
// - Odd path power-down bit 0 switches off odd sample-hold and gain stage.
// - Even path power-down bit 1 switches off even sample-hold and gain stage.
// - Converter power-down switches off only the converter, references stay powered.
// - Clamp DAC power-down bit 4 stops the DAC and floats its output.
// - Bit 5 disables top and bottom converter reference buffers.
// - Bit 6 disables the mid reference buffer.
// - Clamp enable bit 5, reset one, enables clamping; source bit picks method.
// - Source 0 closes the switch while the reset strobe is high.
// - Source 1 closes the switch only while both strobes are high.
`timescale 1ns/1ps
`default_nettype none
`include "afe_setup_defs.svh"

module afe_setup_control_regs (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Register write port
  input  wire afe_setup_pkg::afe_wr_req_t wr_req,
  // Register read port
  input  wire logic                       rd_en,
  input  wire logic [7:0]                 rd_addr,
  output logic [7:0]                      rd_data,
  output logic                            rd_valid,
  // Mode inputs from the other setup registers
  input  wire logic                       single_channel_mode,
  input  wire logic                       cds_mode,
  // Sample strobe pins
  input  wire logic                       reset_sample_strobe,
  input  wire logic                       video_sample_strobe,
  // Clamp reference DAC
  output logic [3:0]                      clamp_dac_code,
  output logic                            clamp_dac_oe,
  // Analogue controls
  output afe_setup_pkg::afe_pd_ctrl_t     pd_ctrl,
  output logic                            odd_channel_active,
  output logic                            even_channel_active,
  output logic                            reset_sample_point,
  output logic                            clamp_switch_closed
);
  import afe_setup_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [3:0] clamp_ref_dac_code_q;
  logic [1:0] reset_sample_shift_q;
  logic       single_channel_mode_channel_sel_q;
  logic       odd_path_powerdown_q;
  logic       even_path_powerdown_q;
  logic       adc_core_powerdown_q;
  logic       clamp_dac_powerdown_q;
  logic       converter_ref_buffer_off_q;
  logic       mid_ref_buffer_off_q;
  logic       clamp_enable_q;
  logic       clamp_switch_source_q;
  logic       soft_reset;
  logic       wr_setup3;
  logic       wr_setup5;
  logic       wr_setup6;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] rs_sync_q;
  logic [1:0] vs_sync_q;
  logic       rs_sync;
  logic       vs_sync;

  // Strobes come from the sensor timing pins, not from this clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rs_sync_q <= 2'h0;
      vs_sync_q <= 2'h0;
    end else begin
      rs_sync_q <= {rs_sync_q[0], reset_sample_strobe};
      vs_sync_q <= {vs_sync_q[0], video_sample_strobe};
    end
  end

  assign rs_sync = rs_sync_q[1];
  assign vs_sync = vs_sync_q[1];

  // ****************************************
  // Write decode
  // ****************************************
  assign soft_reset = afe_hit(wr_req, `AFE_ADDR_SOFT_RESET);
  assign wr_setup3  = afe_hit(wr_req, `AFE_ADDR_CLAMP_CDS_SINGLE_CHANNEL_MODE);
  assign wr_setup5  = afe_hit(wr_req, `AFE_ADDR_POWER_DOWN);
  assign wr_setup6  = afe_hit(wr_req, `AFE_ADDR_CLAMP_CONTROL);

  // ****************************************
  // Clamp, sample shift and channel select
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst || soft_reset) begin
      clamp_ref_dac_code_q <= `AFE_RST_DAC_CODE;
      reset_sample_shift_q <= `AFE_RST_SHIFT;
      single_channel_mode_channel_sel_q   <= `AFE_RST_SINGLE_CHANNEL_MODE_SEL;
    end else if (wr_setup3) begin
      clamp_ref_dac_code_q <= wr_req.data[`AFE_DAC_CODE_MSB:`AFE_DAC_CODE_LSB];
      reset_sample_shift_q <= wr_req.data[`AFE_SHIFT_MSB:`AFE_SHIFT_LSB];
      single_channel_mode_channel_sel_q   <= wr_req.data[`AFE_SINGLE_CHANNEL_MODE_SEL_BIT];
    end
  end

  // ****************************************
  // Power-down and reference buffers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst || soft_reset) begin
      odd_path_powerdown_q       <= `AFE_RST_PD_BIT;
      even_path_powerdown_q      <= `AFE_RST_PD_BIT;
      adc_core_powerdown_q       <= `AFE_RST_PD_BIT;
      clamp_dac_powerdown_q      <= `AFE_RST_PD_BIT;
      converter_ref_buffer_off_q <= `AFE_RST_PD_BIT;
      mid_ref_buffer_off_q       <= `AFE_RST_PD_BIT;
    end else if (wr_setup5) begin
      odd_path_powerdown_q       <= wr_req.data[`AFE_ODD_PD_BIT];
      even_path_powerdown_q      <= wr_req.data[`AFE_EVEN_PD_BIT];
      adc_core_powerdown_q       <= wr_req.data[`AFE_ADC_PD_BIT];
      clamp_dac_powerdown_q      <= wr_req.data[`AFE_DAC_PD_BIT];
      converter_ref_buffer_off_q <= wr_req.data[`AFE_REF_BUF_OFF_BIT];
      mid_ref_buffer_off_q       <= wr_req.data[`AFE_MID_BUF_OFF_BIT];
    end
  end

  // ****************************************
  // Clamp control
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst || soft_reset) begin
      clamp_enable_q        <= `AFE_RST_CLAMP_EN;
      clamp_switch_source_q <= `AFE_RST_CLAMP_SRC;
    end else if (wr_setup6) begin
      clamp_enable_q        <= wr_req.data[`AFE_CLAMP_EN_BIT];
      clamp_switch_source_q <= wr_req.data[`AFE_CLAMP_SRC_BIT];
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  // Unused bits read as zero; soft reset location is write only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        unique case (rd_addr)
          `AFE_ADDR_CLAMP_CDS_SINGLE_CHANNEL_MODE: rd_data <= {1'b0, single_channel_mode_channel_sel_q,
                                                reset_sample_shift_q, clamp_ref_dac_code_q};
          `AFE_ADDR_POWER_DOWN:     rd_data <= {1'b0, mid_ref_buffer_off_q, converter_ref_buffer_off_q,
                                                clamp_dac_powerdown_q, 1'b0, adc_core_powerdown_q,
                                                even_path_powerdown_q, odd_path_powerdown_q};
          `AFE_ADDR_CLAMP_CONTROL:  rd_data <= {1'b0, clamp_switch_source_q, clamp_enable_q, 5'h00};
          default:                  rd_data <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Analogue control outputs
  // ****************************************
  assign clamp_dac_code = clamp_ref_dac_code_q;
  // DAC floats so an external reference may drive the pin
  assign clamp_dac_oe   = !clamp_dac_powerdown_q;

  // Converter power-down leaves the reference buffers alone: slow to settle
  assign pd_ctrl.odd_path_powerdown       = odd_path_powerdown_q;
  assign pd_ctrl.even_path_powerdown      = even_path_powerdown_q;
  assign pd_ctrl.adc_core_powerdown       = adc_core_powerdown_q;
  assign pd_ctrl.clamp_dac_powerdown      = clamp_dac_powerdown_q;
  assign pd_ctrl.converter_ref_buffer_off = converter_ref_buffer_off_q;
  assign pd_ctrl.mid_ref_buffer_off       = mid_ref_buffer_off_q;

  // Select bit only matters in single channel mode
  always_comb begin
    if (single_channel_mode) begin
      odd_channel_active  = !single_channel_mode_channel_sel_q;
      even_channel_active = single_channel_mode_channel_sel_q;
    end else begin
      odd_channel_active  = 1'b1;
      even_channel_active = 1'b1;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  afe_reset_sample_shift u_shift (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .cds_mode     (cds_mode),
    .shift_code   (reset_sample_shift_q),
    .strobe       (rs_sync),
    .sample_point (reset_sample_point)
  );

  afe_clamp_switch u_clamp (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .clamp_enable        (clamp_enable_q),
    .clamp_switch_source (clamp_switch_source_q),
    .reset_strobe        (rs_sync),
    .video_strobe        (vs_sync),
    .switch_closed       (clamp_switch_closed)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_SOFT_RESET_DEFAULTS: assert property (
    soft_reset |=> clamp_dac_code == `AFE_RST_DAC_CODE && reset_sample_shift_q == `AFE_RST_SHIFT
      && !single_channel_mode_channel_sel_q && pd_ctrl == '0 && clamp_enable_q && !clamp_switch_source_q)
    else $error("soft reset did not restore defaults");

  AST_DAC_CODE_WRITE: assert property (
    wr_setup3 |=> clamp_dac_code == $past(wr_req.data[3:0]))
    else $error("clamp DAC code not taken from write");

  AST_SHIFT_WRITE: assert property (
    wr_setup3 |=> reset_sample_shift_q == $past(wr_req.data[5:4]))
    else $error("reset sample shift not taken from write");

  AST_SHIFT_ADVANCE: assert property (
    $rose(rs_sync) && cds_mode && reset_sample_shift_q == 2'b00 |=> $rose(reset_sample_point))
    else $error("advanced reset sample not one cycle after strobe");

  AST_SHIFT_DELAY_TWO: assert property (
    $rose(rs_sync) ##0 (cds_mode && reset_sample_shift_q == 2'b11 && !soft_reset)[*4]
      |=> $rose(reset_sample_point))
    else $error("reset sample delayed by two not four cycles after strobe");

  AST_SINGLE_CHANNEL_MODE_IGNORED: assert property (
    !single_channel_mode && $changed(single_channel_mode_channel_sel_q) |-> odd_channel_active && even_channel_active)
    else $error("channel select acted in two channel mode");

  AST_SINGLE_CHANNEL_MODE_SELECT: assert property (
    single_channel_mode |-> odd_channel_active != even_channel_active
      && even_channel_active == single_channel_mode_channel_sel_q)
    else $error("wrong channel chosen in single channel mode");

  AST_ODD_PD: assert property (
    wr_setup5 |=> pd_ctrl.odd_path_powerdown == $past(wr_req.data[0]))
    else $error("odd path power-down not from bit 0");

  AST_EVEN_PD: assert property (
    wr_setup5 |=> pd_ctrl.even_path_powerdown == $past(wr_req.data[1]))
    else $error("even path power-down not from bit 1");

  AST_ADC_ONLY: assert property (
    wr_setup5 && wr_req.data[2] && !wr_req.data[5] && !wr_req.data[6]
      |=> pd_ctrl.adc_core_powerdown && !pd_ctrl.converter_ref_buffer_off && !pd_ctrl.mid_ref_buffer_off)
    else $error("converter power-down touched the references");

  AST_DAC_FLOAT: assert property (
    wr_setup5 |=> clamp_dac_oe == !$past(wr_req.data[4]))
    else $error("clamp DAC drive not governed by bit 4");

  AST_REF_BUF: assert property (
    wr_setup5 |=> pd_ctrl.converter_ref_buffer_off == $past(wr_req.data[5]))
    else $error("reference buffer control not from bit 5");

  AST_MID_BUF: assert property (
    wr_setup5 |=> pd_ctrl.mid_ref_buffer_off == $past(wr_req.data[6]))
    else $error("mid buffer control not from bit 6");

  AST_CLAMP_EN_WRITE: assert property (
    wr_setup6 |=> clamp_enable_q == $past(wr_req.data[5]) && clamp_switch_source_q == $past(wr_req.data[6]))
    else $error("clamp control not taken from write");

  AST_CLAMP_DIRECT: assert property (
    clamp_enable_q && !clamp_switch_source_q |=> clamp_switch_closed == $past(rs_sync))
    else $error("clamp switch does not follow reset strobe");

  AST_CLAMP_AND: assert property (
    clamp_enable_q && clamp_switch_source_q |=> clamp_switch_closed == ($past(rs_sync) && $past(vs_sync)))
    else $error("clamp switch does not follow both strobes");

  AST_CLAMP_OFF: assert property (
    !clamp_enable_q |=> !clamp_switch_closed)
    else $error("clamp switch closed while clamping disabled");

  // Mux reads the shift code live, so the code must hold up to the sample point
  AST_SHIFT_DEFAULT: assert property (
    $rose(rs_sync) ##0 (cds_mode && reset_sample_shift_q == 2'b01)[*3] |-> $rose(reset_sample_point))
    else $error("default reset sample not two cycles after strobe");

  AST_SHIFT_DELAY_ONE: assert property (
    $rose(rs_sync) ##0 (cds_mode && reset_sample_shift_q == 2'b10)[*4] |-> $rose(reset_sample_point))
    else $error("reset sample delayed by one not three cycles after strobe");

  AST_SHIFT_PLAIN: assert property (
    $rose(rs_sync) ##0 (!cds_mode)[*3] |-> $rose(reset_sample_point))
    else $error("reset sample outside correlated mode not at default position");

  AST_HW_RESET_DEFAULTS: assert property (
    $fell(rst) |-> clamp_dac_code == `AFE_RST_DAC_CODE && reset_sample_shift_q == `AFE_RST_SHIFT
      && !single_channel_mode_channel_sel_q && pd_ctrl == '0 && clamp_enable_q && !clamp_switch_source_q
      && !clamp_switch_closed && !reset_sample_point && !rd_valid)
    else $error("register bank not at defaults after reset");

  // Read in the cycle of a write returns the old value
  AST_READ_CDS_SINGLE_CHANNEL_MODE: assert property (
    rd_en && rd_addr == `AFE_ADDR_CLAMP_CDS_SINGLE_CHANNEL_MODE
      |=> rd_data[3:0] == $past(clamp_dac_code) && rd_data[5:4] == $past(reset_sample_shift_q)
      && rd_data[6] == $past(single_channel_mode_channel_sel_q) && !rd_data[7])
    else $error("clamp setup readback wrong");

  AST_READ_POWER_DOWN: assert property (
    rd_en && rd_addr == `AFE_ADDR_POWER_DOWN
      |=> rd_data[0] == $past(pd_ctrl.odd_path_powerdown) && rd_data[2] == $past(pd_ctrl.adc_core_powerdown)
      && rd_data[6] == $past(pd_ctrl.mid_ref_buffer_off) && !rd_data[3] && !rd_data[7])
    else $error("power-down readback wrong");

  AST_READ_CLAMP_CONTROL: assert property (
    rd_en && rd_addr == `AFE_ADDR_CLAMP_CONTROL
      |=> rd_data == {1'b0, $past(clamp_switch_source_q), $past(clamp_enable_q), 5'h00})
    else $error("clamp control readback wrong");

  AST_READ_SOFT_RESET: assert property (
    rd_en && rd_addr == `AFE_ADDR_SOFT_RESET |=> rd_data == 8'h00)
    else $error("soft reset location did not read as zero");

  AST_DAC_HOLD: assert property (
    !wr_setup3 && !soft_reset |=> $stable(clamp_dac_code) && $stable(reset_sample_shift_q)
      && $stable(single_channel_mode_channel_sel_q))
    else $error("clamp setup changed without a write");

  AST_PD_HOLD: assert property (
    !wr_setup5 && !soft_reset |=> $stable(pd_ctrl))
    else $error("power-down controls changed without a write");

  AST_CLAMP_HOLD: assert property (
    !wr_setup6 && !soft_reset |=> $stable(clamp_enable_q) && $stable(clamp_switch_source_q))
    else $error("clamp control changed without a write");

endmodule : afe_setup_control_regs
`default_nettype wire

//--- afe_setup_defs.svh
// Offsets, field positions, reset values and timing counts of the setup registers
`ifndef AFE_SETUP_DEFS_SVH
`define AFE_SETUP_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define AFE_ADDR_CLAMP_CDS_SINGLE_CHANNEL_MODE   8'h03
`define AFE_ADDR_SOFT_RESET       8'h04
`define AFE_ADDR_POWER_DOWN       8'h05
`define AFE_ADDR_CLAMP_CONTROL    8'h06

// ****************************************
// Field positions
// ****************************************
`define AFE_DAC_CODE_MSB          3
`define AFE_DAC_CODE_LSB          0
`define AFE_SHIFT_MSB             5
`define AFE_SHIFT_LSB             4
`define AFE_SINGLE_CHANNEL_MODE_SEL_BIT          6
`define AFE_ODD_PD_BIT            0
`define AFE_EVEN_PD_BIT           1
`define AFE_ADC_PD_BIT            2
`define AFE_DAC_PD_BIT            4
`define AFE_REF_BUF_OFF_BIT       5
`define AFE_MID_BUF_OFF_BIT       6
`define AFE_CLAMP_EN_BIT          5
`define AFE_CLAMP_SRC_BIT         6

// ****************************************
// Reset values
// ****************************************
`define AFE_RST_DAC_CODE          4'hf
`define AFE_RST_SHIFT             2'h1
`define AFE_RST_SINGLE_CHANNEL_MODE_SEL          1'h0
`define AFE_RST_PD_BIT            1'h0
`define AFE_RST_CLAMP_EN          1'h1
`define AFE_RST_CLAMP_SRC         1'h0

// ****************************************
// Timing counts
// ****************************************
`define AFE_SHIFT_TAPS            4

`endif

//--- afe_setup_pkg.sv
// Types shared by the setup register bank and its helpers
package afe_setup_pkg;

  // Write request from the serial interface decoder
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } afe_wr_req_t;

  // Analogue power and buffer controls
  typedef struct packed {
    logic odd_path_powerdown;
    logic even_path_powerdown;
    logic adc_core_powerdown;
    logic clamp_dac_powerdown;
    logic converter_ref_buffer_off;
    logic mid_ref_buffer_off;
  } afe_pd_ctrl_t;

  function automatic logic afe_hit(input afe_wr_req_t req, input logic [7:0] addr);
    afe_hit = req.en && (req.addr == addr);
  endfunction : afe_hit

endpackage : afe_setup_pkg

//--- afe_reset_sample_shift.sv
// Moves the reset sample point of correlated double sampling by whole clocks
`timescale 1ns/1ps
`default_nettype none
`include "afe_setup_defs.svh"

module afe_reset_sample_shift (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       cds_mode,
  input  wire logic [1:0] shift_code,
  // Strobe in and moved sample point out
  input  wire logic       strobe,
  output logic            sample_point
);
  import afe_setup_pkg::*;

  logic [`AFE_SHIFT_TAPS-1:0] taps_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      taps_q <= '0;
    end else begin
      taps_q <= {taps_q[`AFE_SHIFT_TAPS-2:0], strobe};
    end
  end

  // Tap 1 is the default, so advancing by one needs no negative delay
  always_comb begin
    if (cds_mode) begin
      sample_point = taps_q[shift_code];
    end else begin
      sample_point = taps_q[`AFE_RST_SHIFT];
    end
  end

endmodule : afe_reset_sample_shift
`default_nettype wire

//--- afe_clamp_switch.sv
// Drives the reset level clamp switch from the sample strobes
`timescale 1ns/1ps
`default_nettype none

module afe_clamp_switch (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Control
  input  wire logic clamp_enable,
  input  wire logic clamp_switch_source,
  // Strobes
  input  wire logic reset_strobe,
  input  wire logic video_strobe,
  // Switch
  output logic      switch_closed
);
  import afe_setup_pkg::*;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      switch_closed <= 1'b0;
    end else if (!clamp_enable) begin
      switch_closed <= 1'b0;
    end else if (clamp_switch_source) begin
      switch_closed <= reset_strobe && video_strobe;
    end else begin
      switch_closed <= reset_strobe;
    end
  end

endmodule : afe_clamp_switch
`default_nettype wire

//--- afe_host_model.sv
// Host controller model on the setup register port
`timescale 1ns/1ps
`default_nettype none
`include "afe_setup_defs.svh"

module afe_host_model (
  // Clock
  input  wire logic                  ref_clk,
  // Register port
  output afe_setup_pkg::afe_wr_req_t wr_req,
  output logic                       rd_en,
  output logic [7:0]                 rd_addr,
  input  wire logic [7:0]            rd_data,
  input  wire logic                  rd_valid
);
  import afe_setup_pkg::*;

  initial begin
    wr_req  = '0;
    rd_en   = 1'h0;
    rd_addr = 8'h00;
  end

  // ****************************************
  // Used bits per location
  // ****************************************
  function automatic logic [7:0] used_mask(input logic [7:0] addr);
    case (addr)
      `AFE_ADDR_CLAMP_CDS_SINGLE_CHANNEL_MODE: used_mask = 8'h7f;
      `AFE_ADDR_POWER_DOWN:     used_mask = 8'h77;
      `AFE_ADDR_CLAMP_CONTROL:  used_mask = 8'h60;
      default:                  used_mask = 8'hff;
    endcase
  endfunction : used_mask

  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    #1;
    wr_req.en   = 1'h1;
    wr_req.addr = addr;
    wr_req.data = data & used_mask(addr);
    @(posedge ref_clk);
    #1;
    wr_req.en   = 1'h0;
  endtask : write_reg

  // Answer is registered, so it is taken one edge after the request
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge ref_clk);
    #1;
    rd_en   = 1'h1;
    rd_addr = addr;
    @(posedge ref_clk);
    #1;
    ok      = rd_valid;
    data    = rd_data;
    rd_en   = 1'h0;
  endtask : read_reg

  task automatic power_up();
    write_reg(`AFE_ADDR_SOFT_RESET, 8'h00);
  endtask : power_up

endmodule : afe_host_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the setup register bank
`timescale 1ns/1ps
`default_nettype none
`include "afe_setup_defs.svh"
`define CHECK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h expected %h", $time, (act), (exp)); end end

module tb_top;
  import afe_setup_pkg::*;

  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  afe_wr_req_t wr_req;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        single_channel_mode = 1'h0;
  logic        cds_mode = 1'h0;
  logic        reset_sample_strobe = 1'h0;
  logic        video_sample_strobe = 1'h0;
  logic [3:0]  clamp_dac_code;
  logic        clamp_dac_oe;
  afe_pd_ctrl_t pd_ctrl;
  logic        odd_channel_active;
  logic        even_channel_active;
  logic        reset_sample_point;
  logic        clamp_switch_closed;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          seed = 32'h96fd3a76;
  int          r3, r5, r6, n;
  logic [7:0]  rdv;
  logic        ok;
  logic [7:0]  pick [8] = '{8'h03, 8'h05, 8'h06, 8'h03, 8'h05, 8'h06, 8'h04, 8'h07};
  logic [7:0]  probe [7] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'hff};

  always #5 ref_clk = ~ref_clk;

  afe_setup_control_regs i_dut (.ref_clk(ref_clk), .rst(rst), .wr_req(wr_req), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .single_channel_mode(single_channel_mode),
    .cds_mode(cds_mode), .reset_sample_strobe(reset_sample_strobe), .video_sample_strobe(video_sample_strobe),
    .clamp_dac_code(clamp_dac_code), .clamp_dac_oe(clamp_dac_oe), .pd_ctrl(pd_ctrl),
    .odd_channel_active(odd_channel_active), .even_channel_active(even_channel_active),
    .reset_sample_point(reset_sample_point), .clamp_switch_closed(clamp_switch_closed));

  afe_host_model i_host (.ref_clk(ref_clk), .wr_req(wr_req), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid));

  // ****************************************
  // Reference model
  // ****************************************
  task automatic model_reset();
    r3 = 32'h1f;
    r5 = 0;
    r6 = 32'h20;
  endtask : model_reset

  function automatic int exp_rd(input logic [7:0] a);
    case (a)
      8'h03:   exp_rd = r3;
      8'h05:   exp_rd = r5;
      8'h06:   exp_rd = r6;
      default: exp_rd = 0;
    endcase
  endfunction : exp_rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(a, d);
    case (a)
      8'h03: r3 = d & i_host.used_mask(a);
      8'h05: r5 = d & i_host.used_mask(a);
      8'h06: r6 = d & i_host.used_mask(a);
      8'h04: model_reset();
      default: ;
    endcase
  endtask : wr

  task automatic check_all();
    `CHECK(clamp_dac_code, r3[3:0])
    `CHECK(clamp_dac_oe, ~r5[4])
    `CHECK(pd_ctrl.odd_path_powerdown, r5[0])
    `CHECK(pd_ctrl.even_path_powerdown, r5[1])
    `CHECK(pd_ctrl.adc_core_powerdown, r5[2])
    `CHECK(pd_ctrl.clamp_dac_powerdown, r5[4])
    `CHECK(pd_ctrl.converter_ref_buffer_off, r5[5])
    `CHECK(pd_ctrl.mid_ref_buffer_off, r5[6])
    `CHECK(odd_channel_active, ~single_channel_mode | ~r3[6])
    `CHECK(even_channel_active, ~single_channel_mode | r3[6])
    for (int i = 0; i < 7; i++) begin
      i_host.read_reg(probe[i], rdv, ok);
      `CHECK(ok, 1'h1)
      `CHECK(rdv, exp_rd(probe[i]) & 8'hff)
    end
  endtask : check_all

  task automatic finish_test();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Whole run is well under a thousand cycles
  initial begin
    #500000;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    i_host.power_up();
    model_reset();
    check_all();
    repeat (24) begin
      single_channel_mode = $random(seed);
      wr(pick[$random(seed) & 7], $random(seed));
      check_all();
    end
    for (int i = 0; i < 4; i++) begin
      single_channel_mode = i[1];
      wr(8'h03, {1'h0, i[0], 6'h15});
      check_all();
    end
    wr(8'h05, 8'h77);
    wr(8'h04, $random(seed));
    check_all();
    // Strobes settle through the synchroniser before each look
    for (int i = 0; i < 16; i++) begin
      wr(8'h06, {1'h0, i[3], i[2], 5'h00});
      reset_sample_strobe = i[1];
      video_sample_strobe = i[0];
      repeat (4) @(posedge ref_clk);
      #1;
      `CHECK(clamp_switch_closed, i[2] & (i[3] ? (i[1] & i[0]) : i[1]))
    end
    reset_sample_strobe = 1'h0;
    for (int i = 0; i < 5; i++) begin
      cds_mode = (i < 4);
      wr(8'h03, {2'h0, i[1:0], 4'hf});
      repeat (8) @(posedge ref_clk);
      #1;
      `CHECK(reset_sample_point, 1'h0)
      reset_sample_strobe = 1'h1;
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (reset_sample_point !== 1'h1 && n < 20);
      `CHECK(n, (i < 4) ? 3 + i : 4)
      reset_sample_strobe = 1'h0;
    end
    finish_test();
  end

endmodule : tb_top
`default_nettype wire
